/* File: lsf_led_sink_flash_sequencer.sv */
`timescale 1ns/1ps
`include "lsf_defines.svh"

// Behaviour
// (R1) Bit 15 selects steady LED operation (0) or flash operation (1).
// (R2) In flash operation bit 14 picks the trigger: drive request bit (0) or GPIO flash pin (1).
// (R3) The trigger source bit is ignored in steady LED operation.
// (R4) In LED operation bit 13 switches the sink off (0) or on (1).
// (R5) With the software trigger, a 0-to-1 change of the drive request bit starts a flash.
// (R6) After a software flash the drive request bit clears itself when the flash length ends.
// (R7) With the GPIO trigger selected, the drive request bit does not affect flashing.
// (R8) With the GPIO trigger selected, a rising GPIO flash pin starts a flash.
// (R9) With repeat select 0, each trigger event gives exactly one flash.
// (R10) With repeat select 1, a flash is triggered internally every four seconds.
// (R11) Bits 9:8 give flash length 32, 64, 96 or 1024 ms.
// (R12) Bits 5:4 give the switch-off ramp: instant, 0.25/0.5/1 s (LED) or 1.95/3.91/7.8 ms (flash).
// (R13) The power state machine reset returns every field to its default.
// (R14) Bits 1:0 give the switch-on ramp with the same settings as switch-off.
// (R15) The sink conducts only while its master enable is set.
// (R16) Flash length runs from the trigger, ramps wrap it, and triggers during a flash are ignored; here the ramp-up counts inside the length.
// (R17) Flash length, ramps and repeat interval all count one low-frequency tick.
module lsf_led_sink_flash_sequencer #(
    parameter int          TICK_DIV      = `LSF_TICK_CYCLES,
    parameter logic        DRIVE_DEFAULT = 1'b0
) (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_sm_reset,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    input  wire logic        i_sink_master_enable,
    input  wire logic        i_gpio_flash,
    output logic             o_sink_on,
    output logic             o_ramping_up,
    output logic             o_ramping_down,
    output logic             o_flash_active
);

    ////////////////////////////////////////////////////////////////////////////
    // Interval lookup

    function automatic lsf_pkg::lsf_tick_type ramp_ticks(input logic [1:0] code,
                                                          input logic       flash);
        ramp_ticks = '0;
        case (code)
            2'd1:    ramp_ticks = flash ? 13'(`LSF_US2TICK(`LSF_RAMP_FL_US_1))
                                        : 13'(`LSF_US2TICK(`LSF_RAMP_LED_US_1));
            2'd2:    ramp_ticks = flash ? 13'(`LSF_US2TICK(`LSF_RAMP_FL_US_2))
                                        : 13'(`LSF_US2TICK(`LSF_RAMP_LED_US_2));
            2'd3:    ramp_ticks = flash ? 13'(`LSF_US2TICK(`LSF_RAMP_FL_US_3))
                                        : 13'(`LSF_US2TICK(`LSF_RAMP_LED_US_3));
            default: ramp_ticks = '0;
        endcase
    endfunction : ramp_ticks

    function automatic lsf_pkg::lsf_tick_type flash_ticks(input logic [1:0] code);
        flash_ticks = '0;
        case (code)
            2'd0:    flash_ticks = 13'(`LSF_US2TICK(`LSF_FLASH_US_0));
            2'd1:    flash_ticks = 13'(`LSF_US2TICK(`LSF_FLASH_US_1));
            2'd2:    flash_ticks = 13'(`LSF_US2TICK(`LSF_FLASH_US_2));
            default: flash_ticks = 13'(`LSF_US2TICK(`LSF_FLASH_US_3));
        endcase
    endfunction : flash_ticks

    localparam lsf_pkg::lsf_tick_type REPEAT_TICKS = 13'(`LSF_US2TICK(`LSF_REPEAT_US));

    ////////////////////////////////////////////////////////////////////////////
    // Register fields

    logic                     func_flash_q;
    logic                     trig_gpio_q;
    logic                     drive_q;
    logic                     drive_prev_q;
    logic                     repeat_q;
    logic [1:0]               len_code_q;
    logic [1:0]               down_code_q;
    logic [1:0]               up_code_q;
    logic [15:0]              rdata_q;

    wire  logic               reg_hit      = (i_reg_addr == `LSF_REG_ADDR);
    wire  logic               reg_write    = reg_hit & i_reg_wr;
    wire  logic [15:0]        reg_value    = {func_flash_q, trig_gpio_q, drive_q, repeat_q,
                                              2'b00, len_code_q, 2'b00, down_code_q,
                                              2'b00, up_code_q};

    ////////////////////////////////////////////////////////////////////////////
    // Time base and GPIO synchroniser

    logic [14:0]              div_q;
    lsf_pkg::lsf_tick_type    rep_cnt_q;
    logic                     gpio_s1_q;
    logic                     gpio_s2_q;
    logic                     gpio_prev_q;

    wire  logic               tick         = (div_q == 15'(TICK_DIV - 1));   // [R17]
    wire  logic               repeat_on    = func_flash_q & repeat_q;
    wire  logic               repeat_fire  = repeat_on & tick
                                             & (rep_cnt_q == REPEAT_TICKS - 13'd1); // [R10]

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    lsf_pkg::lsf_state_type   state_q;
    lsf_pkg::lsf_state_type   state_d;
    lsf_pkg::lsf_tick_type    phase_cnt_q;
    lsf_pkg::lsf_tick_type    flash_cnt_q;
    logic                     sw_flash_q;

    // Triggers reach the sequencer only in flash operation
    wire  logic               sw_trig      = func_flash_q & ~trig_gpio_q
                                             & drive_q & ~drive_prev_q;        // [R2] [R5] [R7]
    wire  logic               gpio_trig    = func_flash_q & trig_gpio_q
                                             & gpio_s2_q & ~gpio_prev_q;       // [R2] [R8]
    wire  logic               trigger      = sw_trig | gpio_trig | repeat_fire; // [R9]

    wire  lsf_pkg::lsf_tick_type up_len    = ramp_ticks(up_code_q, func_flash_q);   // [R14]
    wire  lsf_pkg::lsf_tick_type down_len  = ramp_ticks(down_code_q, func_flash_q); // [R12]
    wire  lsf_pkg::lsf_tick_type fl_len    = flash_ticks(len_code_q);               // [R11]

    // LED mode follows the drive bit; trigger source plays no part
    wire  logic               start_req    = func_flash_q ? trigger : drive_q;    // [R1] [R3] [R4]
    wire  logic               flash_done   = func_flash_q & tick
                                             & (flash_cnt_q + 13'd1 >= fl_len); // [R16]
    wire  logic               stop_req     = func_flash_q ? flash_done : ~drive_q; // [R4]
    wire  logic               up_done      = (up_len == '0)
                                             | (tick & (phase_cnt_q + 13'd1 >= up_len));
    wire  logic               down_done    = (down_len == '0)
                                             | (tick & (phase_cnt_q + 13'd1 >= down_len));
    wire  logic               busy         = (state_q != lsf_pkg::LSF_IDLE);
    wire  logic               hw_clear     = flash_done & sw_flash_q & busy;    // [R6]
    wire  logic               new_flash    = (state_q == lsf_pkg::LSF_IDLE)
                                             & func_flash_q & i_sink_master_enable & trigger;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            lsf_pkg::LSF_IDLE:      // Triggers while busy never get here [R16]
                if (start_req)
                    state_d = lsf_pkg::LSF_RAMP_UP;
            lsf_pkg::LSF_RAMP_UP:
                if (stop_req)
                    state_d = lsf_pkg::LSF_RAMP_DOWN;
                else if (up_done)
                    state_d = lsf_pkg::LSF_ON;
            lsf_pkg::LSF_ON:
                if (stop_req)
                    state_d = lsf_pkg::LSF_RAMP_DOWN;
            lsf_pkg::LSF_RAMP_DOWN:
                if (down_done)
                    state_d = lsf_pkg::LSF_IDLE;
            default:
                state_d = lsf_pkg::LSF_IDLE;
        endcase
        // Dropping the master enable cuts the sink at once, no ramp
        if (!i_sink_master_enable)
            state_d = lsf_pkg::LSF_IDLE;                                          // [R15]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flops

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            func_flash_q <= 1'b0;
            trig_gpio_q  <= 1'b0;
            drive_q      <= DRIVE_DEFAULT;
            repeat_q     <= 1'b0;
            len_code_q   <= 2'b00;
            down_code_q  <= 2'b00;
            up_code_q    <= 2'b00;
        end
        else if (i_sm_reset)
        begin
            func_flash_q <= 1'b0;                                                 // [R13]
            trig_gpio_q  <= 1'b0;
            drive_q      <= DRIVE_DEFAULT;
            repeat_q     <= 1'b0;
            len_code_q   <= 2'b00;
            down_code_q  <= 2'b00;
            up_code_q    <= 2'b00;
        end
        else if (reg_write)
        begin
            // A write in the clearing cycle wins over the hardware clear
            func_flash_q <= i_reg_wdata[`LSF_BIT_FUNC];
            trig_gpio_q  <= i_reg_wdata[`LSF_BIT_TRIGSRC];
            drive_q      <= i_reg_wdata[`LSF_BIT_DRIVE];
            repeat_q     <= i_reg_wdata[`LSF_BIT_REPEAT];
            len_code_q   <= i_reg_wdata[`LSF_FLD_LEN_HI:`LSF_FLD_LEN_LO];
            down_code_q  <= i_reg_wdata[`LSF_FLD_DOWN_HI:`LSF_FLD_DOWN_LO];
            up_code_q    <= i_reg_wdata[`LSF_FLD_UP_HI:`LSF_FLD_UP_LO];
        end
        else if (hw_clear)
        begin
            drive_q      <= 1'b0;                                                 // [R6]
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            drive_prev_q <= 1'b0;
            rdata_q      <= `LSF_REG_RESET;
        end
        else
        begin
            drive_prev_q <= drive_q;
            rdata_q      <= reg_hit ? (reg_value & `LSF_REG_MASK) : 16'h0000;
        end
    end

    // Free running, so the first tick after a trigger may come early
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            div_q     <= '0;
            rep_cnt_q <= '0;
        end
        else
        begin
            div_q <= tick ? 15'h0000 : div_q + 15'h0001;
            if (!repeat_on)
                rep_cnt_q <= '0;
            else if (tick)
                rep_cnt_q <= repeat_fire ? 13'h0000 : rep_cnt_q + 13'h0001;  // [R10]
        end
    end

    // Pin is asynchronous: two flops before any logic reads it
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            gpio_s1_q   <= 1'b0;
            gpio_s2_q   <= 1'b0;
            gpio_prev_q <= 1'b0;
        end
        else
        begin
            gpio_s1_q   <= i_gpio_flash;
            gpio_s2_q   <= gpio_s1_q;
            gpio_prev_q <= gpio_s2_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q     <= lsf_pkg::LSF_IDLE;
            phase_cnt_q <= '0;
            flash_cnt_q <= '0;
            sw_flash_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (state_d != state_q)
                phase_cnt_q <= '0;
            else if (tick)
                phase_cnt_q <= phase_cnt_q + 13'h0001;
            // Length counts from the trigger itself, across the ramp-up
            if (new_flash)
            begin
                flash_cnt_q <= '0;                                                // [R16]
                sw_flash_q  <= sw_trig;
            end
            else if (tick && busy)
                flash_cnt_q <= flash_cnt_q + 13'h0001;
        end
    end

    // Taken from the next state so the outputs move with state_q
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_sink_on      <= 1'b0;
            o_ramping_up   <= 1'b0;
            o_ramping_down <= 1'b0;
            o_flash_active <= 1'b0;
        end
        else
        begin
            o_sink_on      <= (state_d != lsf_pkg::LSF_IDLE);                    // [R15]
            o_ramping_up   <= (state_d == lsf_pkg::LSF_RAMP_UP);
            o_ramping_down <= (state_d == lsf_pkg::LSF_RAMP_DOWN);
            o_flash_active <= (state_d != lsf_pkg::LSF_IDLE) & func_flash_q;
        end
    end

    assign o_reg_rdata = rdata_q;

endmodule : lsf_led_sink_flash_sequencer

/* File: lsf_defines.svh */
`ifndef LSF_DEFINES_SVH
`define LSF_DEFINES_SVH

// Register location and field positions
`define LSF_REG_ADDR          8'hAD
`define LSF_REG_RESET         16'h0000
`define LSF_BIT_FUNC          15
`define LSF_BIT_TRIGSRC       14
`define LSF_BIT_DRIVE         13
`define LSF_BIT_REPEAT        12
`define LSF_FLD_LEN_HI        9
`define LSF_FLD_LEN_LO        8
`define LSF_FLD_DOWN_HI       5
`define LSF_FLD_DOWN_LO       4
`define LSF_FLD_UP_HI         1
`define LSF_FLD_UP_LO         0
`define LSF_REG_MASK          16'hF333

// Clock and low-frequency time base
`define LSF_CLK_HZ            20000000
`define LSF_TICK_HZ           1024
`define LSF_TICK_CYCLES       (`LSF_CLK_HZ / `LSF_TICK_HZ)

// Intervals in microseconds, as printed
`define LSF_FLASH_US_0        32000
`define LSF_FLASH_US_1        64000
`define LSF_FLASH_US_2        96000
`define LSF_FLASH_US_3        1024000
`define LSF_RAMP_LED_US_1     250000
`define LSF_RAMP_LED_US_2     500000
`define LSF_RAMP_LED_US_3     1000000
`define LSF_RAMP_FL_US_1      1950
`define LSF_RAMP_FL_US_2      3910
`define LSF_RAMP_FL_US_3      7800
`define LSF_REPEAT_US         4000000

// Least time in ticks, rounded up
`define LSF_US2TICK(us) \
    ((64'd0 + (us)) * 64'd1024 + 64'd999999) / 64'd1000000

`endif

/* File: lsf_pkg.sv */
package lsf_pkg;

    typedef enum logic [1:0] {
        LSF_IDLE,
        LSF_RAMP_UP,
        LSF_ON,
        LSF_RAMP_DOWN
    } lsf_state_type;

    typedef logic [12:0] lsf_tick_type;

endpackage : lsf_pkg

/* File: lsf_chk_assertions.sv */
`timescale 1ns/1ps
module lsf_chk (
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_sm_reset,
    input wire logic [7:0]  i_reg_addr,
    input wire logic        i_reg_wr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic [15:0] o_reg_rdata,
    input wire logic        i_sink_master_enable,
    input wire logic        o_sink_on,
    input wire logic        o_ramping_up,
    input wire logic        o_ramping_down,
    input wire logic        o_flash_active
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_read_mask: assert property (
        (o_reg_rdata & 16'h0CCC) == 16'h0000) else $error("unused bits read high");
    a_unmapped_zero: assert property (
        i_reg_addr != 8'hAD |=> o_reg_rdata == 16'h0000) else $error("other address reads");
    a_write_readback: assert property (
        i_reg_wr && i_reg_addr == 8'hAD && !i_sm_reset ##1 i_reg_addr == 8'hAD && !i_sm_reset
        |=> (o_reg_rdata & 16'hD333) == ($past(i_reg_wdata, 2) & 16'hD333))
        else $error("written fields lost");
    a_sm_reset_clear: assert property (
        i_sm_reset && i_reg_addr == 8'hAD ##1 i_reg_addr == 8'hAD |=> o_reg_rdata == 16'h0000)
        else $error("fields survive state machine reset");
    a_enable_cuts: assert property (
        !i_sink_master_enable [*3] |-> !o_sink_on) else $error("sink on while disabled");
    a_flash_on: assert property (
        o_flash_active |-> o_sink_on) else $error("flash without sink");
    a_ramp_excl: assert property (
        !(o_ramping_up && o_ramping_down)) else $error("both ramps at once");
    a_ramp_on: assert property (
        (o_ramping_up || o_ramping_down) |-> o_sink_on) else $error("ramp with sink off");
    a_no_reramp: assert property (
        o_sink_on && !o_ramping_up |=> !o_ramping_up) else $error("ramp-up restarted while lit");
endmodule : lsf_chk

bind lsf_led_sink_flash_sequencer lsf_chk i_chk (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_sm_reset(i_sm_reset), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_sink_master_enable(i_sink_master_enable), .o_sink_on(o_sink_on),
    .o_ramping_up(o_ramping_up), .o_ramping_down(o_ramping_down),
    .o_flash_active(o_flash_active));

/* File: lsf_host_model.sv */
`timescale 1ns/1ps
module lsf_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_reg_rdata,
    output logic      [7:0]  o_reg_addr,
    output logic             o_reg_wr,
    output logic      [15:0] o_reg_wdata,
    output logic             o_gpio_flash
);
    initial
    begin
        o_reg_addr   = 8'hAD;
        o_reg_wr     = 1'b0;
        o_reg_wdata  = 16'h0000;
        o_gpio_flash = 1'b0;
    end
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(negedge i_clk);
        o_reg_addr  = a;
        o_reg_wdata = d;
        o_reg_wr    = 1'b1;
        @(negedge i_clk);
        o_reg_wr    = 1'b0;
        // Stale data inverted so a late capture shows up
        o_reg_wdata = ~d;
        o_reg_addr  = 8'hAD;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(negedge i_clk);
        o_reg_addr = a;
        @(negedge i_clk);
        d          = i_reg_rdata;
        o_reg_addr = 8'hAD;
    endtask : read_reg
    task automatic gpio_pulse();
        @(negedge i_clk);
        o_gpio_flash = 1'b1;
        repeat (8) @(negedge i_clk);
        o_gpio_flash = 1'b0;
    endtask : gpio_pulse
endmodule : lsf_host_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int TDIV = 4;
    logic i_clk, i_nrst, i_sm_reset, i_sink_master_enable, reg_wr, gpio;
    logic o_sink_on, o_ramping_up, o_ramping_down, o_flash_active;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, o_reg_rdata, rd;
    int fails, samples_checked, n, n1, n2, u, d;
    int len_us[4]      = '{32000, 64000, 96000, 1024000};
    int fl_ramp_us[4]  = '{0, 1950, 3910, 7800};
    int led_ramp_us[4] = '{0, 250000, 500000, 1000000};
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    lsf_led_sink_flash_sequencer #(.TICK_DIV(TDIV), .DRIVE_DEFAULT(1'b0)) i_dut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_sm_reset(i_sm_reset), .i_reg_addr(reg_addr),
        .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_sink_master_enable(i_sink_master_enable), .i_gpio_flash(gpio),
        .o_sink_on(o_sink_on), .o_ramping_up(o_ramping_up),
        .o_ramping_down(o_ramping_down), .o_flash_active(o_flash_active));
    lsf_host_model i_host (.i_clk(i_clk), .i_reg_rdata(o_reg_rdata), .o_reg_addr(reg_addr),
        .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata), .o_gpio_flash(gpio));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic sig(input int k);
        case (k)
            0: return o_sink_on;
            1: return o_ramping_up;
            2: return o_ramping_down;
            default: return o_reg_rdata[13];
        endcase
    endfunction : sig
    // Model: fewest whole 1024 Hz ticks that cover an interval
    function automatic int model_ticks(input longint us);
        return int'((us * 1024 + 999999) / 1000000);
    endfunction : model_ticks
    task automatic results();
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic check_bit(input string nm, input logic s, input logic e);
        samples_checked++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value %s expected %b seen %b", nm, e, s);
        end
    endtask : check_bit
    task automatic check_word(input string nm, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : check_word
    // Tick phase is free running, so timings get a small tolerance
    task automatic check_near(input string nm, input int e, input int s, input int tol);
        samples_checked++;
        if (s < e - tol || s > e + tol)
        begin
            fails++;
            $display("wrong value %s expected %0d seen %0d", nm, e, s);
        end
    endtask : check_near
    task automatic wait_for(input int k, input logic v, input int mx, output int c);
        c = 0;
        while (sig(k) !== v && c < mx)
        begin
            @(negedge i_clk);
            c++;
        end
        if (c >= mx)
        begin
            fails++;
            $display("wrong value wait %0d expected %b seen %b", k, v, sig(k));
            results();
        end
    endtask : wait_for
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {i_nrst, i_sm_reset, i_sink_master_enable} = 3'b000;
        void'($urandom(32'h4f8debbc));
        repeat (3) @(negedge i_clk);
        i_nrst = 1'b1;
        i_host.read_reg(8'hAD, rd);
        check_word("reset", rd, 16'h0000);
        i_host.write_reg(8'hAD, 16'hFFFF);
        i_host.read_reg(8'hAD, rd);
        check_word("mask", rd, 16'hF333);
        i_host.write_reg(8'hAC, 16'h0000);
        i_host.read_reg(8'hAC, rd);
        check_word("other", rd, 16'h0000);
        i_host.read_reg(8'hAD, rd);
        check_word("kept", rd, 16'hF333);
        i_sm_reset = 1'b1;
        i_host.write_reg(8'hAD, 16'hFFFF);
        i_sm_reset = 1'b0;
        i_host.read_reg(8'hAD, rd);
        check_word("sm_reset", rd, 16'h0000);
        i_sink_master_enable = 1'b1;
        i_host.write_reg(8'hAD, 16'h6010);
        wait_for(0, 1'b1, 10, n);
        check_bit("led_flash", o_flash_active, 1'b0);
        i_host.write_reg(8'hAD, 16'h0010);
        wait_for(2, 1'b1, 10, n);
        wait_for(2, 1'b0, 1200, n);
        check_near("led_down", model_ticks(led_ramp_us[1]) * TDIV, n, 6);
        wait_for(0, 1'b0, 5, n);
        i_host.write_reg(8'hAD, 16'h2000);
        wait_for(0, 1'b1, 10, n);
        i_sink_master_enable = 1'b0;
        repeat (3) @(negedge i_clk);
        check_bit("enable", o_sink_on, 1'b0);
        i_host.write_reg(8'hAD, 16'h0000);
        i_sink_master_enable = 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            u  = $urandom % 4;
            d  = $urandom % 4;
            n1 = 0;
            i_host.write_reg(8'hAD, 16'hA000 | 16'(c << 8) | 16'(d << 4) | 16'(u));
            wait_for(0, 1'b1, 10, n);
            check_bit("flash", o_flash_active, 1'b1);
            if (u != 0)
                wait_for(1, 1'b0, 60, n1);
            if (u != 0)
                check_near("ramp_up", model_ticks(fl_ramp_us[u]) * TDIV, n1, 6);
            wait_for(3, 1'b0, 5000, n2);
            check_near("length", model_ticks(len_us[c]) * TDIV, n + n1 + n2, 8);
            if (d != 0)
                wait_for(2, 1'b0, 60, n);
            if (d != 0)
                check_near("ramp_down", model_ticks(fl_ramp_us[d]) * TDIV, n, 6);
            wait_for(0, 1'b0, 60, n);
        end
        i_host.write_reg(8'hAD, 16'hC000);
        i_host.write_reg(8'hAD, 16'hE000);
        repeat (12) @(negedge i_clk);
        check_bit("drive_ignored", o_sink_on, 1'b0);
        i_host.gpio_pulse();
        wait_for(0, 1'b1, 12, n);
        wait_for(0, 1'b0, 400, n);
        repeat (200) @(negedge i_clk);
        check_bit("one_flash", o_sink_on, 1'b0);
        i_host.write_reg(8'hAD, 16'h0000);
        i_host.write_reg(8'hAD, 16'h9000);
        wait_for(0, 1'b1, 16500, n);
        wait_for(0, 1'b0, 400, n1);
        wait_for(0, 1'b1, 16500, n2);
        check_near("repeat", model_ticks(4000000) * TDIV, n1 + n2, 8);
        results();
    end
endmodule : tb_top
